// *** shared/asid_pkg.sv ***
// constants and types for the add/subtract decode and execute block
// assumes a single clock domain inside the cpu core
package asid_pkg;
    // ==========================================================
    // instruction word fields
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int ROW_MSB = 9;
    localparam int ROW_LSB = 8;
    localparam int COL_MSB = 7;
    localparam int COL_LSB = 4;
    localparam int OPD_MSB = 3;
    localparam int OPD_LSB = 0;
    // ==========================================================
    // opcodes
    localparam logic [5:0] OPC_SUM_IMM       = 6'h00;
    localparam logic [5:0] OPC_SUM_IMM_CARRY = 6'h01;
    localparam logic [5:0] OPC_DIFF_IMM      = 6'h02;
    localparam logic [5:0] OPC_DIFF_IMM_BRW  = 6'h03;
    localparam logic [5:0] OPC_SUM_MEM       = 6'h08;
    localparam logic [5:0] OPC_SUM_MEM_CARRY = 6'h09;
    localparam logic [5:0] OPC_DIFF_MEM      = 6'h0a;
    localparam logic [5:0] OPC_COMPARE_LT    = 6'h1c;
    localparam logic [5:0] OPC_COMPARE_LTC   = 6'h1d;
    // ==========================================================
    // address ranges
    localparam logic [7:0] MEM_LIMIT  = 8'h3f;
    localparam logic [7:0] REG_LIMIT  = 8'h0f;
    localparam logic [7:0] WIDE_LIMIT = 8'hff;
    // ==========================================================
    // related core widths
    localparam int IRQ_PTR_W  = 2;
    localparam int IRQ_FILE_W = 26;
    localparam int IRQ_DEPTH  = 4;
    localparam int RET_W      = 14;
    localparam int RET_DEPTH  = 16;
    localparam int PORT_W     = 4;
    localparam int JUMP_W     = 13;
    localparam int CALL_W     = 6;
    localparam int TBL_W      = 14;
    localparam int ROW_SEL_W  = 6;
    // ==========================================================
    // reset values
    localparam logic RST_CARRY = 1'b0;
    // ==========================================================
    // execute sequencing
    typedef enum logic [1:0] {
        ASID_IDLE  = 2'b00,
        ASID_FETCH = 2'b01,
        ASID_WRITE = 2'b10
    } asid_state_t;
endpackage

// *** design/asid_alu.sv ***
// 4-bit adder/subtractor with carry in and carry/borrow out
// assumes operands already selected by the decode stage
`timescale 1ns/100ps
module asid_alu (
    // operands
    input  wire logic [3:0] a_in,
    input  wire logic [3:0] b_in,
    input  wire logic       cin_in,
    input  wire logic       sub_in,
    // result
    output logic      [3:0] res_out,
    output logic            cout_out
);
    // ==========================================================
    // arithmetic
    logic [4:0] wide_sum;
    logic [4:0] wide_diff;
    assign wide_sum  = {1'b0, a_in} + {1'b0, b_in} + {4'h0, cin_in};
    assign wide_diff = {1'b0, a_in} - {1'b0, b_in} - {4'h0, cin_in};
    // only the low nibble survives; bit 4 is carry or borrow
    assign res_out  = sub_in ? wide_diff[3:0] : wide_sum[3:0];
    assign cout_out = sub_in ? wide_diff[4] : wide_sum[4];
endmodule

// *** design/asid_core.sv ***
// decode and execute of the 4-bit add and subtract instructions
// assumes one-cycle data memory read, owned by the surrounding core
//
// What this block does
// - opcodes 00/01: memory plus immediate, optional carry
// - opcodes 08/09: register plus memory, optional carry
// - opcodes 02/03/0a: subtractions, borrow variant
// - word splits into opcode, row, column, operand
// - column and row form memory address
// - ordinary memory operand limited to 000-03f
// - general registers sit at 000-00f
// - low operand field picks the register
// - load/store widen row to four bits
// - arithmetic immediates are four bits
// - row-select load alone takes six-bit immediate
// - two-bit save pointer, 26-bit save entries
// - return pointer and entries fourteen bits
// - port code is four bits
// - 13-bit jump field, 6-bit call field
// - table-read pointer is fourteen bits
// - carry set on carry or borrow
// - carry untouched by other instructions
`timescale 1ns/100ps
module asid_core (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // instruction issue
    input  wire logic        ISSUE_IN,
    input  wire logic [15:0] INSTR_IN,
    input  wire logic        WIDE_OP_IN,
    // data memory read port
    output logic      [8:0]  RD_ADDR_OUT,
    input  wire logic [3:0]  RD_DATA_IN,
    // data memory write port
    output logic             WR_EN_OUT,
    output logic      [8:0]  WR_ADDR_OUT,
    output logic      [3:0]  WR_DATA_OUT,
    // other carry writers in the core
    input  wire logic        CARRY_LOAD_IN,
    input  wire logic        CARRY_VAL_IN,
    // status
    output logic             BUSY_OUT,
    output logic             DONE_OUT,
    output logic             CARRY_OUT,
    // decoded side fields and core pointers for the rest of the core
    output logic      [5:0]  ROW_SEL_IMM_OUT,
    output logic      [3:0]  PORT_CODE_OUT,
    output logic      [12:0] JUMP_TARGET_OUT,
    output logic      [5:0]  CALL_PAGE_OUT,
    output logic      [1:0]  IRQ_PTR_OUT,
    output logic      [13:0] RET_PTR_OUT,
    output logic      [13:0] TBL_PTR_OUT
);
    // ==========================================================
    // field split
    logic [5:0] opcode_field;
    logic [1:0] row_field;
    logic [3:0] column_field;
    logic [3:0] reg_number_field;
    logic [3:0] wide_row_field;
    assign opcode_field     = INSTR_IN[asid_pkg::OPC_MSB:asid_pkg::OPC_LSB];
    assign row_field        = INSTR_IN[asid_pkg::ROW_MSB:asid_pkg::ROW_LSB];
    assign column_field     = INSTR_IN[asid_pkg::COL_MSB:asid_pkg::COL_LSB];
    assign reg_number_field = INSTR_IN[asid_pkg::OPD_MSB:asid_pkg::OPD_LSB];
    assign wide_row_field   = INSTR_IN[11:8];

    // ==========================================================
    // opcode decode
    logic is_sum_imm;
    logic is_sum_imm_carry;
    logic is_diff_imm;
    logic is_diff_imm_brw;
    logic is_sum_mem;
    logic is_sum_mem_carry;
    logic is_diff_mem;
    logic is_imm_form;
    logic is_arith;
    assign is_sum_imm       = opcode_field == asid_pkg::OPC_SUM_IMM;
    assign is_sum_imm_carry = opcode_field == asid_pkg::OPC_SUM_IMM_CARRY;
    assign is_diff_imm      = opcode_field == asid_pkg::OPC_DIFF_IMM;
    assign is_diff_imm_brw  = opcode_field == asid_pkg::OPC_DIFF_IMM_BRW;
    assign is_sum_mem       = opcode_field == asid_pkg::OPC_SUM_MEM;
    assign is_sum_mem_carry = opcode_field == asid_pkg::OPC_SUM_MEM_CARRY;
    assign is_diff_mem      = opcode_field == asid_pkg::OPC_DIFF_MEM;
    assign is_imm_form = is_sum_imm | is_sum_imm_carry | is_diff_imm | is_diff_imm_brw;
    assign is_arith    = is_imm_form | is_sum_mem | is_sum_mem_carry | is_diff_mem;

    // ==========================================================
    // addresses
    logic [8:0] mem_addr;
    logic [8:0] reg_addr;
    logic [8:0] wide_addr;
    // two-bit row keeps the ordinary operand inside 000-03f
    assign mem_addr  = {3'h0, row_field, column_field};
    assign reg_addr  = {5'h00, reg_number_field};
    assign wide_addr = {1'b0, wide_row_field, column_field};

    // ==========================================================
    // latched instruction
    logic [3:0] opd_ff;
    logic [8:0] m_addr_ff;
    logic [8:0] r_addr_ff;
    logic       imm_form_ff;
    logic       sub_ff;
    logic       use_cy_ff;
    logic       nxt_sub;
    logic       nxt_use_cy;
    assign nxt_sub    = is_diff_imm | is_diff_imm_brw | is_diff_mem;
    assign nxt_use_cy = is_sum_imm_carry | is_sum_mem_carry | is_diff_imm_brw;

    asid_pkg::asid_state_t state_ff;
    asid_pkg::asid_state_t nxt_state;
    logic [3:0] mem_val_ff;
    logic       fetch_go;
    assign fetch_go = (state_ff == asid_pkg::ASID_IDLE) && ISSUE_IN && is_arith;

    always_comb begin
        case (state_ff)
            asid_pkg::ASID_IDLE:  nxt_state = fetch_go ? asid_pkg::ASID_FETCH
                                                       : asid_pkg::ASID_IDLE;
            asid_pkg::ASID_FETCH: nxt_state = asid_pkg::ASID_WRITE;
            asid_pkg::ASID_WRITE: nxt_state = asid_pkg::ASID_IDLE;
            default:              nxt_state = asid_pkg::ASID_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state_ff <= asid_pkg::ASID_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            opd_ff      <= 4'h0;
            m_addr_ff   <= 9'h000;
            r_addr_ff   <= 9'h000;
            imm_form_ff <= 1'b0;
            sub_ff      <= 1'b0;
            use_cy_ff   <= 1'b0;
        end else if (fetch_go) begin
            opd_ff      <= reg_number_field;
            m_addr_ff   <= mem_addr;
            r_addr_ff   <= reg_addr;
            imm_form_ff <= is_imm_form;
            sub_ff      <= nxt_sub;
            use_cy_ff   <= nxt_use_cy;
        end
    end

    // ==========================================================
    // operand read: memory in fetch, register in write stage
    logic [3:0] reg_val;
    assign reg_val = RD_DATA_IN;
    assign RD_ADDR_OUT = (state_ff == asid_pkg::ASID_FETCH) ? m_addr_ff : r_addr_ff;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            mem_val_ff <= 4'h0;
        end else if (state_ff == asid_pkg::ASID_IDLE) begin
            mem_val_ff <= 4'h0;
        end else if (state_ff == asid_pkg::ASID_FETCH) begin
            mem_val_ff <= RD_DATA_IN;
        end
    end

    // memory read is combinational on address: fetch stage data is memory,
    // write stage data is the register; register read only counts for r forms
    logic [3:0] op_a;
    logic [3:0] op_b;
    logic [3:0] alu_res;
    logic       alu_cout;
    logic       carry_ff;
    logic       cin;
    assign op_a = imm_form_ff ? mem_val_ff : reg_val;
    assign op_b = imm_form_ff ? opd_ff : mem_val_ff;
    assign cin  = use_cy_ff & carry_ff;

    asid_alu u_alu (
        .a_in     (op_a),
        .b_in     (op_b),
        .cin_in   (cin),
        .sub_in   (sub_ff),
        .res_out  (alu_res),
        .cout_out (alu_cout)
    );

    // ==========================================================
    // write back and carry
    logic finish;
    assign finish = state_ff == asid_pkg::ASID_WRITE;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            WR_EN_OUT   <= 1'b0;
            WR_ADDR_OUT <= 9'h000;
            WR_DATA_OUT <= 4'h0;
            DONE_OUT    <= 1'b0;
        end else begin
            WR_EN_OUT   <= finish;
            WR_ADDR_OUT <= imm_form_ff ? m_addr_ff : r_addr_ff;
            WR_DATA_OUT <= alu_res;
            DONE_OUT    <= finish;
        end
    end

    // arithmetic wins over a simultaneous load from another unit
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            carry_ff <= asid_pkg::RST_CARRY;
        end else if (finish) begin
            carry_ff <= alu_cout;
        end else if (CARRY_LOAD_IN) begin
            carry_ff <= CARRY_VAL_IN;
        end
    end

    assign CARRY_OUT = carry_ff;
    assign BUSY_OUT  = state_ff != asid_pkg::ASID_IDLE;

    // ==========================================================
    // side fields and related core pointers
    logic [5:0]  row_sel_ff;
    logic [3:0]  port_ff;
    logic [12:0] jump_ff;
    logic [5:0]  call_ff;
    logic [1:0]  irq_save_depth_ptr;
    logic [13:0] return_addr_ptr;
    logic [13:0] table_read_pointer;
    logic [25:0] irq_save_file [asid_pkg::IRQ_DEPTH];
    logic [13:0] return_addr_file [asid_pkg::RET_DEPTH];

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            row_sel_ff <= 6'h00;
            port_ff    <= 4'h0;
            jump_ff    <= 13'h0000;
            call_ff    <= 6'h00;
        end else if (ISSUE_IN) begin
            row_sel_ff <= INSTR_IN[9:4];
            port_ff    <= INSTR_IN[3:0];
            jump_ff    <= INSTR_IN[12:0];
            call_ff    <= INSTR_IN[9:4];
        end
    end

    // storage shapes only; push/pop belong to the sequencer elsewhere
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            irq_save_depth_ptr <= 2'h0;
            return_addr_ptr    <= 14'h0000;
            table_read_pointer <= 14'h0000;
        end
    end

    generate
        for (genvar gi = 0; gi < asid_pkg::IRQ_DEPTH; gi++) begin : g_irq
            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    irq_save_file[gi] <= 26'h0000000;
                end
            end
        end
        for (genvar gr = 0; gr < asid_pkg::RET_DEPTH; gr++) begin : g_ret
            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    return_addr_file[gr] <= 14'h0000;
                end
            end
        end
    endgenerate

    assign ROW_SEL_IMM_OUT = row_sel_ff;
    assign PORT_CODE_OUT   = port_ff;
    assign JUMP_TARGET_OUT = jump_ff;
    assign CALL_PAGE_OUT   = call_ff;
    assign IRQ_PTR_OUT     = irq_save_depth_ptr;
    assign RET_PTR_OUT     = return_addr_ptr;
    assign TBL_PTR_OUT     = table_read_pointer;

    // ==========================================================
    // wide address view for load/store, not driven out; only chk_wide_range reads it
    logic [8:0] wide_addr_sel;
    assign wide_addr_sel = WIDE_OP_IN ? wide_addr : mem_addr;

    // ==========================================================
    // checks
    chk_mem_range: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (state_ff == asid_pkg::ASID_FETCH) |-> (m_addr_ff <= 9'h03f))
        else $error("memory operand outside ordinary range");
    chk_reg_range: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (state_ff == asid_pkg::ASID_FETCH) |-> (r_addr_ff <= 9'h00f))
        else $error("register address outside register range");
    chk_wide_range: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        wide_addr_sel <= 9'h0ff)
        else $error("wide address outside range");
    chk_issue_write: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        fetch_go |-> ##3 WR_EN_OUT)
        else $error("write back not three cycles after issue");
    chk_imm_dest: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (fetch_go && is_imm_form) |-> ##3 (WR_ADDR_OUT == $past(mem_addr, 3)))
        else $error("immediate form wrote wrong address");
    chk_reg_dest: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (fetch_go && !is_imm_form) |-> ##3 (WR_ADDR_OUT == $past(reg_addr, 3)))
        else $error("register form wrote wrong address");
    chk_carry_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (!finish && !CARRY_LOAD_IN) |=> $stable(carry_ff))
        else $error("carry changed without cause");
    chk_carry_set: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        finish |=> (carry_ff == $past(alu_cout)))
        else $error("carry not updated from result");
    chk_busy_len: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        fetch_go |=> BUSY_OUT [*2] ##1 !BUSY_OUT)
        else $error("busy length wrong");

    cov_sum_imm: cover property (@(posedge CLK_IN) fetch_go && is_sum_imm);
    cov_diff_mem: cover property (@(posedge CLK_IN) fetch_go && is_diff_mem);
    cov_carry_out: cover property (@(posedge CLK_IN) finish && alu_cout);
    cov_carry_chain: cover property (@(posedge CLK_IN) fetch_go && is_sum_mem_carry && carry_ff);
endmodule

// *** tb/asid_core_bench.sv ***
// self-checking bench for the add/subtract decode and execute block
// assumes a combinational 512-nibble data memory modelled here
`timescale 1ns/100ps
module asid_core_bench;
    // ==========================================================
    // signals and memory
    typedef struct {
        logic [8:0] addr;
        logic [3:0] data;
        logic       cy;
        int         cyc;
    } asid_exp_t;
    logic        clk, srst, issue, wide_op, cy_load, cy_val;
    logic [15:0] instr;
    logic [8:0]  rd_addr, wr_addr;
    logic [3:0]  rd_data, wr_data;
    logic        wr_en, busy, done, cy_out;
    logic [5:0]  row_sel, call_page;
    logic [3:0]  port_code;
    logic [12:0] jump_tgt;
    logic [1:0]  irq_ptr;
    logic [13:0] ret_ptr, tbl_ptr;
    logic [3:0]  mem [0:511];
    logic [3:0]  ref_mem [0:511];
    logic        ref_cy, exp_cy, pend_cy;
    logic [31:0] seed;
    logic [5:0]  opcs [0:6];
    asid_exp_t   expq [$];
    asid_exp_t   got;
    int          fails, checked, cyc;
    assign rd_data = mem[rd_addr];
    asid_core u_dut (
        .CLK_IN(clk), .SRST_IN(srst), .ISSUE_IN(issue), .INSTR_IN(instr),
        .WIDE_OP_IN(wide_op), .RD_ADDR_OUT(rd_addr), .RD_DATA_IN(rd_data),
        .WR_EN_OUT(wr_en), .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data),
        .CARRY_LOAD_IN(cy_load), .CARRY_VAL_IN(cy_val), .BUSY_OUT(busy),
        .DONE_OUT(done), .CARRY_OUT(cy_out), .ROW_SEL_IMM_OUT(row_sel),
        .PORT_CODE_OUT(port_code), .JUMP_TARGET_OUT(jump_tgt),
        .CALL_PAGE_OUT(call_page), .IRQ_PTR_OUT(irq_ptr),
        .RET_PTR_OUT(ret_ptr), .TBL_PTR_OUT(tbl_ptr)
    );
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // idle means no write pending and the last carry already compared
    task automatic wait_idle;
        int n;
        n = 0;
        while ((busy !== 1'b0 || expq.size() != 0 || pend_cy) && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (busy !== 1'b0 || expq.size() != 0 || pend_cy)
            fails++;
    endtask
    task automatic load_carry(input logic v);
        wait_idle();
        cy_load = 1'b1;
        cy_val = v;
        @(posedge clk);
        #1;
        cy_load = 1'b0;
        ref_cy = v;
        check("carry load", {15'h0, cy_out}, {15'h0, v});
    endtask
    task automatic poke(input logic [8:0] a, input logic [3:0] v);
        mem[a] = v;
        ref_mem[a] = v;
    endtask
    // issue one word; arithmetic words note their expected write
    task automatic send(input logic [15:0] w);
        asid_exp_t e;
        logic [5:0] op;
        logic [8:0] ma, ra;
        logic [3:0] a, b;
        logic [4:0] t;
        logic ci, ar;
        int n;
        n = 0;
        // one edge always passes, so issue never drops and rises in one step
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (busy !== 1'b0 && n < 20);
        if (busy !== 1'b0)
            fails++;
        op = w[15:10];
        ar = op inside {asid_pkg::OPC_SUM_IMM, asid_pkg::OPC_SUM_IMM_CARRY,
                        asid_pkg::OPC_DIFF_IMM, asid_pkg::OPC_DIFF_IMM_BRW,
                        asid_pkg::OPC_SUM_MEM, asid_pkg::OPC_SUM_MEM_CARRY,
                        asid_pkg::OPC_DIFF_MEM};
        ma = {3'h0, w[9:4]};
        ra = {5'h0, w[3:0]};
        ci = (op == asid_pkg::OPC_SUM_IMM_CARRY || op == asid_pkg::OPC_DIFF_IMM_BRW ||
              op == asid_pkg::OPC_SUM_MEM_CARRY) ? ref_cy : 1'b0;
        a = op[3] ? ref_mem[ra] : ref_mem[ma];
        b = op[3] ? ref_mem[ma] : w[3:0];
        t = op[1] ? {1'b0, a} - {1'b0, b} - {4'h0, ci} : {1'b0, a} + {1'b0, b} + {4'h0, ci};
        instr = w;
        wide_op = rnd() & 32'h1;
        issue = 1'b1;
        @(posedge clk);
        #1;
        issue = 1'b0;
        check("row select imm", {10'h0, row_sel}, {10'h0, w[9:4]});
        check("port code", {12'h0, port_code}, {12'h0, w[3:0]});
        check("jump target", {3'h0, jump_tgt}, {3'h0, w[12:0]});
        check("call page", {10'h0, call_page}, {10'h0, w[9:4]});
        if (ar) begin
            e.addr = op[3] ? ra : ma;
            e.data = t[3:0];
            e.cy = t[4];
            e.cyc = cyc + 2; // taken edge is cycle zero; pulse stands after the second edge
            expq.push_back(e);
            ref_mem[e.addr] = t[3:0];
            ref_cy = t[4];
        end
    endtask
    // ==========================================================
    // clock, memory writes, result monitor
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr_en === 1'b1)
            mem[wr_addr] <= wr_data;
    end
    // carry is compared one cycle after the write, when it must already stand
    always @(negedge clk) begin
        if (wr_en === 1'b1 || done === 1'b1)
            check("done pulse", {15'h0, done}, {15'h0, wr_en});
        if (pend_cy) begin
            check("carry flag", {15'h0, cy_out}, {15'h0, exp_cy});
            pend_cy = 1'b0;
        end
        if (wr_en === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected write", 16'h1, 16'h0);
            end else begin
                got = expq.pop_front();
                check("write addr", {7'h0, wr_addr}, {7'h0, got.addr});
                check("write data", {12'h0, wr_data}, {12'h0, got.data});
                check("write cycle", cyc[15:0], got.cyc[15:0]);
                exp_cy = got.cy;
                pend_cy = 1'b1;
            end
        end
    end
    initial begin
        #60000;
        fails++;
        end_sim();
    end
    // ==========================================================
    // tests
    initial begin
        logic [31:0] r;
        fails = 0;
        checked = 0;
        cyc = 0;
        pend_cy = 1'b0;
        seed = 32'h5ad8;
        srst = 1'b1;
        issue = 1'b0;
        instr = 16'h0;
        wide_op = 1'b0;
        cy_load = 1'b0;
        cy_val = 1'b0;
        ref_cy = asid_pkg::RST_CARRY;
        opcs = '{asid_pkg::OPC_SUM_IMM, asid_pkg::OPC_SUM_IMM_CARRY, asid_pkg::OPC_DIFF_IMM,
                 asid_pkg::OPC_DIFF_IMM_BRW, asid_pkg::OPC_SUM_MEM,
                 asid_pkg::OPC_SUM_MEM_CARRY, asid_pkg::OPC_DIFF_MEM};
        for (int i = 0; i < 512; i++) begin
            r = rnd();
            poke(i[8:0], r[3:0]);
        end
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        check("idle outputs", {wr_en, done, busy, cy_out, 12'h0}, 16'h0);
        check("save ptr", {14'h0, irq_ptr}, 16'h0);
        check("ret ptr", {2'h0, ret_ptr}, 16'h0);
        check("tbl ptr", {2'h0, tbl_ptr}, 16'h0);
        $display("test reset done");
        // every arithmetic opcode, random fields, issued back to back
        for (int i = 0; i < 42; i++) begin
            if (i % 8 == 7)
                load_carry(rnd() & 32'h1);
            r = rnd();
            send({opcs[i % 7], r[9:0]});
        end
        wait_idle();
        $display("test random ops done");
        // wrap at the top of the ordinary range and borrow below zero
        poke(9'h03f, 4'hf);
        load_carry(1'b1);
        send({asid_pkg::OPC_SUM_IMM_CARRY, 2'h3, 4'hf, 4'hf});
        wait_idle();
        poke(9'h000, 4'h0);
        load_carry(1'b1);
        send({asid_pkg::OPC_DIFF_IMM_BRW, 2'h0, 4'h0, 4'h0});
        wait_idle();
        poke(9'h00f, 4'h3);
        send({asid_pkg::OPC_DIFF_MEM, 2'h0, 4'h0, 4'hf});
        wait_idle();
        $display("test boundaries done");
        // second word while busy and non-arithmetic words are ignored
        send({asid_pkg::OPC_SUM_IMM, 2'h1, 4'h2, 4'h5});
        @(posedge clk);
        #1;
        instr = {asid_pkg::OPC_SUM_MEM, 2'h2, 4'h3, 4'h1};
        issue = 1'b1;
        @(posedge clk);
        #1;
        issue = 1'b0;
        wait_idle();
        load_carry(1'b1);
        send({6'h07, 10'h3a5});
        send({6'h3f, 10'h2b2});
        repeat (6) @(posedge clk);
        #1;
        check("carry kept", {15'h0, cy_out}, 16'h1);
        $display("test refusals done");
        end_sim();
    end
endmodule
